// ---- hdl/tsr_regs.vh ----
`ifndef TSR_REGS_VH
`define TSR_REGS_VH
// Register byte offsets on the bus
`define TSR_OFF_TEMP     8'h00
`define TSR_OFF_SETUP    8'h04
`define TSR_OFF_LOWER    8'h08
`define TSR_OFF_UPPER    8'h0C
`define TSR_OFF_POINTER  8'h10
`define TSR_OFF_SAMPLE   8'h14
`define TSR_OFF_IRQ_STAT 8'h18
`define TSR_OFF_IRQ_MASK 8'h1C
// Power-up defaults
`define TSR_RST_TEMP     16'h0000
`define TSR_RST_UPPER    16'hA000
`define TSR_RST_LOWER    16'h9600
`define TSR_RST_SETUP    8'h00
`define TSR_RST_POINTER  8'h00
// Setup field positions
`define TSR_BIT_SHDN     0
`define TSR_BIT_INTMODE  1
`define TSR_BIT_POL      2
`define TSR_BIT_FQ_LO    3
`define TSR_BIT_RES_LO   5
`define TSR_BIT_ONESHOT  7
// Times in ms, core clock in kHz
`define TSR_CLK_KHZ      10000
`define TSR_T_POWERUP_MS 2
`define TSR_T_CONV9_MS   30
`define TSR_POWERUP_CYC  (`TSR_T_POWERUP_MS * `TSR_CLK_KHZ)
`define TSR_CONV9_CYC    (`TSR_T_CONV9_MS * `TSR_CLK_KHZ)
// Interrupt status bits
`define TSR_IRQ_CONV     0
`define TSR_IRQ_ALERT    1
`endif

// ---- hdl/tsr_sync.v ----
`timescale 1ns/1ns
`default_nettype none
module tsr_sync (
  // Clock and reset
  input  wire i_core_clk,
  input  wire i_rst_n,
  input  wire i_en,
  // Level
  input  wire i_async,
  output wire o_sync
);
  reg meta_reg;
  reg sync_reg;
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else if (i_en) begin
      meta_reg <= i_async;
      sync_reg <= meta_reg;
    end
  end
  assign o_sync = sync_reg;
endmodule
`default_nettype wire

// ---- hdl/tsr_fault.v ----
`timescale 1ns/1ns
`default_nettype none
module tsr_fault (
  // Clock and reset
  input  wire       i_core_clk,
  input  wire       i_rst_n,
  input  wire       i_en,
  // Per-conversion result
  input  wire       i_done,
  input  wire       i_over,
  input  wire       i_under,
  input  wire [1:0] i_fq_sel,
  // Qualified conditions, pulses
  output reg        o_over_q,
  output reg        o_under_q
);
  reg  [2:0] over_cnt_reg;
  reg  [2:0] under_cnt_reg;
  wire [2:0] need;
  // Queue of 1, 2, 4 or 6 conversions
  assign need = (i_fq_sel == 2'b00) ? 3'h1 : (i_fq_sel == 2'b01) ? 3'h2 :
                (i_fq_sel == 2'b10) ? 3'h4 : 3'h6;
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      over_cnt_reg  <= 3'h0;
      under_cnt_reg <= 3'h0;
      o_over_q      <= 1'b0;
      o_under_q     <= 1'b0;
    end else if (i_en) begin
      o_over_q  <= 1'b0;
      o_under_q <= 1'b0;
      if (i_done) begin
        // RQ12 consecutive fault count
        over_cnt_reg  <= i_over ? ((over_cnt_reg < need) ? over_cnt_reg + 3'h1 : need) : 3'h0;
        under_cnt_reg <= i_under ? ((under_cnt_reg < need) ? under_cnt_reg + 3'h1 : need) : 3'h0;
        o_over_q      <= i_over && (over_cnt_reg + 3'h1 >= need);
        o_under_q     <= i_under && (under_cnt_reg + 3'h1 >= need);
      end
    end
  end
endmodule
`default_nettype wire

// ---- hdl/tsr_core.v ----
`timescale 1ns/1ns
`default_nettype none
`include "tsr_regs.vh"
//////////////////////////////////////////////////////////////////////////////
// How it works
// RQ1 - setup bits 6:5 pick 9 to 12 bit resolution
// RQ2 - conversion time 30, 60, 120 or 240 ms, doubling per bit
// RQ3 - resolution code 00=9, 01=10, 10=11, 11=12 bits
// RQ4 - power-on reset returns every register to default
// RQ5 - defaults: temperature 0000, upper A000, lower 9600, pointer temperature
// RQ6 - setup register resets to 00
// RQ7 - 2 ms power-up delay before defaults and first conversion; code loads defaults at reset and delays only writes and the first conversion
// RQ8 - temperature valid only after one full conversion time
// RQ9 - controller programs active-low when alert line is wire-ORed
// RQ10 - bits 7,0 pick mode; one-shot clears bit 7 when done
// RQ11 - bit 1 comparator or interrupt, bit 2 alert polarity
// RQ12 - bits 4:3 fault queue; condition must persist that many conversions
// RQ13 - comparator alert set above upper, released below lower limit
module tsr_core #(
  parameter POWERUP_CYC = `TSR_POWERUP_CYC,
  parameter CONV9_CYC   = `TSR_CONV9_CYC
) (
  // Clock, reset, enable
  input  wire        i_core_clk,
  input  wire        i_rst_n,
  input  wire        i_ce,
  // AHB-Lite slave
  input  wire        i_hsel,
  input  wire [7:0]  i_haddr,
  input  wire [1:0]  i_htrans,
  input  wire        i_hwrite,
  input  wire [2:0]  i_hsize,
  input  wire [31:0] i_hwdata,
  input  wire        i_hready,
  output wire        o_hreadyout,
  output wire        o_hresp,
  output reg  [31:0] o_hrdata,
  // Sampling clock pin from the sensing front end
  input  wire        i_sample_clk,
  // Alert pin, open drain
  output wire        o_alert_out,
  output wire        o_alert_oe,
  output wire        o_alert_level,
  // Interrupt
  output wire        o_irq
);
  localparam ST_PWRUP = 2'h0;
  localparam ST_IDLE  = 2'h1;
  localparam ST_CONV  = 2'h2;

  reg  [15:0] temp_reg;
  reg  [15:0] upper_reg;
  reg  [15:0] lower_reg;
  reg  [7:0]  setup_reg;
  reg  [7:0]  pointer_reg;
  reg  [15:0] sample_reg;
  reg  [1:0]  irq_stat_reg;
  reg  [1:0]  irq_mask_reg;
  reg  [1:0]  state_reg;
  reg  [31:0] cnt_reg;
  reg         valid_reg;
  reg         alert_reg;
  reg         hot_reg;
  reg         sclk_d_reg;
  reg         ph_act_reg;
  reg         ph_wr_reg;
  reg  [7:0]  ph_addr_reg;
  reg         conv_done;
  wire        sclk_s;
  wire        over_q;
  wire        under_q;

  function [31:0] conv_cycles;
    input [1:0] res;
    begin
      // RQ2 doubling conversion
      conv_cycles = CONV9_CYC << res;
    end
  endfunction

  function signed [15:0] tmp9;
    input [15:0] v;
    begin
      tmp9 = {v[15:7], 7'h00};
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Sampling clock crossing; each rising edge counts one front-end tick
  tsr_sync u_sync (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_en       (i_ce),
    .i_async    (i_sample_clk),
    .o_sync     (sclk_s)
  );

  tsr_fault u_fault (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_en       (i_ce),
    .i_done     (conv_done),
    .i_over     ($signed(tmp9(temp_reg)) > $signed(tmp9(upper_reg))),
    .i_under    ($signed(tmp9(temp_reg)) < $signed(tmp9(lower_reg))),
    .i_fq_sel   (setup_reg[`TSR_BIT_FQ_LO+1:`TSR_BIT_FQ_LO]),
    .o_over_q   (over_q),
    .o_under_q  (under_q)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Bus decode
  wire addr_ok = (i_haddr[1:0] == 2'b00) && (i_haddr <= `TSR_OFF_IRQ_MASK);
  wire take    = i_hsel && i_htrans[1] && i_hready;
  wire rd_take = take && !i_hwrite;
  wire rd_stat = rd_take && (i_haddr == `TSR_OFF_IRQ_STAT);
  wire wr_now  = ph_act_reg && ph_wr_reg;
  wire shdn    = setup_reg[`TSR_BIT_SHDN];
  wire oneshot = setup_reg[`TSR_BIT_ONESHOT];
  assign o_hreadyout = 1'b1;
  assign o_hresp     = 1'b0;

  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ph_act_reg  <= 1'b0;
      ph_wr_reg   <= 1'b0;
      ph_addr_reg <= 8'h00;
      o_hrdata    <= 32'h0000_0000;
    end else if (i_ce) begin
      ph_act_reg  <= take && addr_ok;
      ph_wr_reg   <= i_hwrite;
      ph_addr_reg <= i_haddr;
      if (rd_take) begin
        case (i_haddr)
          `TSR_OFF_TEMP:     o_hrdata <= {16'h0000, temp_reg};
          `TSR_OFF_SETUP:    o_hrdata <= {24'h000000, setup_reg};
          `TSR_OFF_LOWER:    o_hrdata <= {16'h0000, lower_reg};
          `TSR_OFF_UPPER:    o_hrdata <= {16'h0000, upper_reg};
          `TSR_OFF_POINTER:  o_hrdata <= {24'h000000, pointer_reg};
          `TSR_OFF_SAMPLE:   o_hrdata <= {15'h0000, valid_reg, sample_reg};
          `TSR_OFF_IRQ_STAT: o_hrdata <= {30'h00000000, irq_stat_reg};
          `TSR_OFF_IRQ_MASK: o_hrdata <= {30'h00000000, irq_mask_reg};
          default:           o_hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Registers and conversion sequencer
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      // RQ4 power-on defaults
      temp_reg     <= `TSR_RST_TEMP;
      // RQ5 printed defaults
      upper_reg    <= `TSR_RST_UPPER;
      lower_reg    <= `TSR_RST_LOWER;
      pointer_reg  <= `TSR_RST_POINTER;
      // RQ6 setup default
      setup_reg    <= `TSR_RST_SETUP;
      sample_reg   <= 16'h0000;
      irq_mask_reg <= 2'h0;
      state_reg    <= ST_PWRUP;
      cnt_reg      <= 32'h0;
      valid_reg    <= 1'b0;
      sclk_d_reg   <= 1'b0;
      conv_done    <= 1'b0;
    end else if (i_ce) begin
      conv_done  <= 1'b0;
      sclk_d_reg <= sclk_s;
      // Front-end ticks accumulate into the raw sample
      if (sclk_s && !sclk_d_reg) begin
        sample_reg <= sample_reg + 16'h0010;
      end
      if (wr_now && state_reg != ST_PWRUP) begin
        case (ph_addr_reg)
          `TSR_OFF_SETUP:   setup_reg   <= i_hwdata[7:0];
          `TSR_OFF_LOWER:   lower_reg   <= {i_hwdata[15:7], 7'h00};
          `TSR_OFF_UPPER:   upper_reg   <= {i_hwdata[15:7], 7'h00};
          `TSR_OFF_POINTER: pointer_reg <= {6'h00, i_hwdata[1:0]};
          `TSR_OFF_IRQ_MASK: irq_mask_reg <= i_hwdata[1:0];
          default: ;
        endcase
      end
      case (state_reg)
        ST_PWRUP: begin
          // RQ7 power-up delay
          if (cnt_reg >= POWERUP_CYC - 1) begin
            cnt_reg   <= 32'h0;
            state_reg <= ST_CONV;
          end else begin
            cnt_reg <= cnt_reg + 32'h1;
          end
        end
        ST_IDLE: begin
          cnt_reg <= 32'h0;
          // RQ10 mode select
          if (!shdn || oneshot) begin
            state_reg <= ST_CONV;
          end
        end
        ST_CONV: begin
          // RQ1 resolution sets the time
          if (cnt_reg >= conv_cycles(setup_reg[`TSR_BIT_RES_LO+1:`TSR_BIT_RES_LO]) - 1) begin
            cnt_reg   <= 32'h0;
            conv_done <= 1'b1;
            // RQ8 first valid data
            valid_reg <= 1'b1;
            // RQ3 keep 9+res bits
            case (setup_reg[6:5])
              2'b00:   temp_reg <= {sample_reg[15:7], 7'h00};
              2'b01:   temp_reg <= {sample_reg[15:6], 6'h00};
              2'b10:   temp_reg <= {sample_reg[15:5], 5'h00};
              default: temp_reg <= {sample_reg[15:4], 4'h0};
            endcase
            // RQ10 one-shot self-clear
            if (shdn) begin
              setup_reg[`TSR_BIT_ONESHOT] <= 1'b0;
              state_reg <= ST_IDLE;
            end
          end else begin
            cnt_reg <= cnt_reg + 32'h1;
          end
        end
        default: state_reg <= ST_PWRUP;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Alert logic
  wire int_mode = setup_reg[`TSR_BIT_INTMODE];
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      alert_reg <= 1'b0;
      hot_reg   <= 1'b0;
    end else if (i_ce) begin
      if (int_mode) begin
        // RQ11 interrupt mode: set on event, any read or shutdown clears
        // Hot flag arms the opposite event, so a cleared alert stays quiet
        if (over_q && !hot_reg || under_q && hot_reg) begin
          alert_reg <= 1'b1;
          hot_reg   <= !hot_reg;
        end else if (rd_take || (shdn && !oneshot)) begin
          alert_reg <= 1'b0;
        end
      end else begin
        // RQ13 comparator hysteresis
        if (over_q) begin
          alert_reg <= 1'b1;
          hot_reg   <= 1'b1;
        end else if (under_q) begin
          alert_reg <= 1'b0;
          hot_reg   <= 1'b0;
        end
      end
    end
  end

  // RQ11 polarity bit
  assign o_alert_level = setup_reg[`TSR_BIT_POL] ? alert_reg : !alert_reg;
  // RQ9 open drain only pulls low
  assign o_alert_out = 1'b0;
  assign o_alert_oe  = !o_alert_level;

  //////////////////////////////////////////////////////////////////////////////
  // Sticky interrupt status; set wins over read-clear
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_stat_reg <= 2'h0;
    end else if (i_ce) begin
      irq_stat_reg <= (rd_stat ? 2'h0 : irq_stat_reg) | {over_q, conv_done};
    end
  end
  assign o_irq = |(irq_stat_reg & irq_mask_reg);
endmodule
`default_nettype wire

// ---- verification/tsr_chk_sva.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "tsr_regs.vh"
module tsr_chk #(
  parameter POWERUP_CYC = 20,
  parameter CONV9_CYC   = 40
) (
  input wire logic        i_core_clk,
  input wire logic        i_rst_n,
  input wire logic        i_ce,
  input wire logic        i_hsel,
  input wire logic [7:0]  i_haddr,
  input wire logic [1:0]  i_htrans,
  input wire logic        i_hwrite,
  input wire logic        i_hready,
  input wire logic        o_hreadyout,
  input wire logic        o_hresp,
  input wire logic [31:0] o_hrdata,
  input wire logic        o_alert_out,
  input wire logic        o_alert_oe,
  input wire logic        o_alert_level,
  input wire logic        o_irq
);
  logic [31:0] cnt;
  logic        rd_take;
  // Margin of two cycles against where the design starts its own count
  assign rd_take = i_hsel && i_htrans[1] && i_hready && !i_hwrite && i_ce;
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n)
      cnt <= 32'h0;
    else if (i_ce && cnt < 32'hFFFF)
      cnt <= cnt + 32'h1;
  end
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  a_ready_zero_wait: assert property (o_hreadyout)
    else $error("wait state inserted");
  a_resp_okay: assert property (!o_hresp)
    else $error("error response given");
  a_pin_open_drain: assert property (o_alert_oe == !o_alert_level && !o_alert_out)
    else $error("alert pin drive wrong");
  a_reset_idle: assert property ($rose(i_rst_n) |-> !o_irq && o_alert_level && o_hrdata == 32'h0)
    else $error("outputs not idle after reset");
  a_temp_default: assert property (rd_take && i_haddr == `TSR_OFF_TEMP
    && cnt < POWERUP_CYC + CONV9_CYC - 2 |=> o_hrdata[15:0] == `TSR_RST_TEMP)
    else $error("temperature changed too early");
  a_upper_default: assert property (rd_take && i_haddr == `TSR_OFF_UPPER
    && cnt < POWERUP_CYC - 2 |=> o_hrdata[15:0] == `TSR_RST_UPPER)
    else $error("upper limit default wrong");
  a_lower_default: assert property (rd_take && i_haddr == `TSR_OFF_LOWER
    && cnt < POWERUP_CYC - 2 |=> o_hrdata[15:0] == `TSR_RST_LOWER)
    else $error("lower limit default wrong");
  a_setup_default: assert property (rd_take && i_haddr == `TSR_OFF_SETUP
    && cnt < POWERUP_CYC - 2 |=> o_hrdata[7:0] == `TSR_RST_SETUP)
    else $error("setup default wrong");
  a_irq_quiet: assert property (cnt < POWERUP_CYC |-> !o_irq)
    else $error("interrupt during power-up");
  a_alert_idle: assert property (cnt < POWERUP_CYC |-> o_alert_level)
    else $error("alert active during power-up");
endmodule
bind tsr_core tsr_chk #(.POWERUP_CYC(POWERUP_CYC), .CONV9_CYC(CONV9_CYC)) i_tsr_chk (
  .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_hsel(i_hsel),
  .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hready(i_hready),
  .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_hrdata(o_hrdata),
  .o_alert_out(o_alert_out), .o_alert_oe(o_alert_oe), .o_alert_level(o_alert_level),
  .o_irq(o_irq));
`default_nettype wire

// ---- verification/tsr_front.sv ----
`timescale 1ns/1ns
`default_nettype none
module tsr_front (
  output var logic o_sample_clk
);
  // Odd start offset keeps the tick edges off the core clock edges, at a fixed phase
  initial begin
    o_sample_clk = 1'b0;
    #137;
    forever begin
      #400;
      o_sample_clk = ~o_sample_clk;
    end
  end
endmodule
`default_nettype wire

// ---- verification/temp_sensor_resolution_and_powerup_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "tsr_regs.vh"
module temp_sensor_resolution_and_powerup_tb;
  localparam PU = 40;
  localparam C9 = 40;
  logic        clk;
  logic        rst_n;
  logic        hsel;
  logic        hwrite;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] rd;
  wire         hrdy;
  wire         hresp;
  wire         aout;
  wire         aoe;
  wire         alvl;
  wire         irq;
  wire         sclk;
  wire  [31:0] hrdata;
  int          fail_count;
  int          total_checks;
  time         t0;
  tsr_core #(.POWERUP_CYC(PU), .CONV9_CYC(C9)) i_tsr_core (
    .i_core_clk(clk), .i_rst_n(rst_n), .i_ce(1'b1), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
    .i_hready(hrdy), .o_hreadyout(hrdy), .o_hresp(hresp), .o_hrdata(hrdata),
    .i_sample_clk(sclk), .o_alert_out(aout), .o_alert_oe(aoe), .o_alert_level(alvl),
    .o_irq(irq));
  tsr_front i_tsr_front (.o_sample_clk(sclk));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  //////////////////////////////////////////////////////////////////////////////
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (hrdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hrdy !== 1'b1);
    rd = hrdata;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rd & m, e);
  endtask
  // Status read clears, then give the level two cycles to drop
  task clr;
    xfer(1'b0, `TSR_OFF_IRQ_STAT, 32'h0);
    repeat (2) @(posedge clk);
  endtask
  task wirq;
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 2000) begin
      fail_count++;
      $display("Error at %0t: no interrupt", $time);
      give_verdict;
    end
  endtask
  task give_verdict;
    $display("Checks %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    #(20000 * 100);
    fail_count++;
    $display("Error at %0t: watchdog expired", $time);
    give_verdict;
  end
  initial begin
    rst_n = 1'b0;
    {hsel, hwrite, haddr, htrans, hwdata} = '0;
    hsize = 3'h2;
    fail_count = 0;
    total_checks = 0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t0 = $time;
    rdchk(`TSR_OFF_TEMP, 32'hFFFF, `TSR_RST_TEMP);
    rdchk(`TSR_OFF_UPPER, 32'hFFFF, `TSR_RST_UPPER);
    rdchk(`TSR_OFF_LOWER, 32'hFFFF, `TSR_RST_LOWER);
    rdchk(`TSR_OFF_POINTER, 32'hFF, `TSR_RST_POINTER);
    rdchk(`TSR_OFF_SETUP, 32'hFF, `TSR_RST_SETUP);
    xfer(1'b1, `TSR_OFF_SETUP, 32'h60);
    rdchk(`TSR_OFF_SETUP, 32'hFF, 32'h0);
    rdchk(8'h20, 32'hFFFFFFFF, 32'h0);
    repeat (PU) @(posedge clk);
    xfer(1'b1, `TSR_OFF_IRQ_MASK, 32'h1);
    wirq;
    chk({31'h0, ($time - t0) >= (PU + C9 - 2) * 100}, 32'h1);
    rdchk(`TSR_OFF_IRQ_STAT, 32'h1, 32'h1);
    xfer(1'b0, `TSR_OFF_TEMP, 32'h0);
    chk({31'h0, rd[15:0] != 16'h0}, 32'h1);
    $display("Power-up test done");
    for (int r = 0; r < 4; r++) begin
      xfer(1'b1, `TSR_OFF_SETUP, r << 5);
      rdchk(`TSR_OFF_SETUP, 32'h60, r << 5);
      clr;
      wirq;
      clr;
      wirq;
      t0 = $time;
      clr;
      wirq;
      chk({31'h0, ($time - t0) / 100 + 3 >= (C9 << r) && ($time - t0) / 100 <= (C9 << r) + 3}, 1);
    end
    $display("Resolution test done");
    xfer(1'b1, `TSR_OFF_SETUP, 32'h0);
    xfer(1'b1, `TSR_OFF_IRQ_MASK, 32'h0);
    repeat (2 * C9) @(posedge clk);
    chk(irq, 32'h0);
    xfer(1'b1, `TSR_OFF_IRQ_MASK, 32'h1);
    repeat (2) @(posedge clk);
    chk(irq, 32'h1);
    // Polarity left active-low, as a shared alert line needs
    xfer(1'b1, `TSR_OFF_UPPER, 32'h0);
    xfer(1'b1, `TSR_OFF_LOWER, 32'h0);
    repeat (2 * C9 + 5) @(posedge clk);
    chk(alvl, 32'h0);
    chk(aoe, 32'h1);
    // Limits above the slowly rising sample, so it sits below the lower one
    xfer(1'b1, `TSR_OFF_SETUP, 32'h18);
    xfer(1'b1, `TSR_OFF_UPPER, 32'h7F80);
    xfer(1'b1, `TSR_OFF_LOWER, 32'h7F00);
    repeat (3 * C9 + 5) @(posedge clk);
    chk(alvl, 32'h0);
    repeat (4 * C9 + 10) @(posedge clk);
    chk(alvl, 32'h1);
    xfer(1'b1, `TSR_OFF_SETUP, 32'h2);
    xfer(1'b1, `TSR_OFF_LOWER, 32'h0);
    xfer(1'b1, `TSR_OFF_UPPER, 32'h0);
    repeat (2 * C9 + 5) @(posedge clk);
    chk(alvl, 32'h0);
    rdchk(`TSR_OFF_SETUP, 32'hFF, 32'h2);
    // Still above the upper limit: no second event until it drops below
    repeat (C9 + 5) @(posedge clk);
    chk(alvl, 32'h1);
    xfer(1'b1, `TSR_OFF_SETUP, 32'h4);
    repeat (C9 + 5) @(posedge clk);
    chk({aoe, alvl}, 32'h1);
    $display("Alert test done");
    xfer(1'b1, `TSR_OFF_SETUP, 32'h1);
    repeat (C9 + 5) @(posedge clk);
    clr;
    repeat (C9 + 5) @(posedge clk);
    rdchk(`TSR_OFF_IRQ_STAT, 32'h1, 32'h0);
    xfer(1'b1, `TSR_OFF_SETUP, 32'h81);
    repeat (C9 + 10) @(posedge clk);
    rdchk(`TSR_OFF_SETUP, 32'h81, 32'h1);
    rdchk(`TSR_OFF_IRQ_STAT, 32'h1, 32'h1);
    xfer(1'b1, `TSR_OFF_LOWER, 32'h0);
    rdchk(`TSR_OFF_LOWER, 32'hFFFF, 32'h0);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rdchk(`TSR_OFF_LOWER, 32'hFFFF, `TSR_RST_LOWER);
    $display("One-shot and reset test done");
    give_verdict;
  end
endmodule
`default_nettype wire
